// file: sgc_pkg.sv
/*
  Shared constants and types for the two-bank graphics DRAM core: command
  codes, address field positions, mode field positions, reset values and
  the storage geometry.
  Assumes the core samples every input on the rising edge of clk_sys.
*/
package sgc_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int DATA_W    = 16;
  localparam int LANES     = 2;
  localparam int ROW_W     = 9;
  localparam int COL_W     = 8;
  localparam int ADDR_W    = 10;
  localparam int GRP_WORDS = 8;                 // Columns touched by one block write.
  localparam int GRP_SEL_W = 3;
  localparam int GRP_W     = COL_W - GRP_SEL_W;
  localparam int MEM_AW    = 1 + ROW_W + GRP_W;
  localparam int MEM_DEPTH = 1 << MEM_AW;
  localparam int WIDE_W    = DATA_W * GRP_WORDS;
  localparam int WIDE_BE   = LANES * GRP_WORDS;

  // ----------------------------------------------------------------------
  // Commands, coded as {select_n, row strobe_n, column strobe_n, write_n}
  // ----------------------------------------------------------------------
  localparam logic [3:0] CMD_MODE  = 4'h0;
  localparam logic [3:0] CMD_PRE   = 4'h2;
  localparam logic [3:0] CMD_ACT   = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ  = 4'h5;
  localparam logic [3:0] CMD_STOP  = 4'h6;

  // ----------------------------------------------------------------------
  // Address field positions
  // ----------------------------------------------------------------------
  localparam int BANK_BIT    = 9;
  localparam int PRE_ALL_BIT = 8;
  localparam int BL_LSB      = 0;
  localparam int BL_W        = 3;
  localparam int BTYPE_BIT   = 3;
  localparam int LAT_LSB     = 4;
  localparam int LAT_W       = 3;
  localparam int SINGLE_BIT  = 9;               // Opcode bit: single-word writes.
  localparam int COLOR_BIT   = 6;
  localparam int WMASK_BIT   = 5;

  // ----------------------------------------------------------------------
  // Burst length codes and the column masks they select
  // ----------------------------------------------------------------------
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [7:0] MASK_1    = 8'h00;
  localparam logic [7:0] MASK_2    = 8'h01;
  localparam logic [7:0] MASK_4    = 8'h03;
  localparam logic [7:0] MASK_8    = 8'h07;
  localparam logic [7:0] MASK_FULL = 8'hff;

  // ----------------------------------------------------------------------
  // Read latency codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] LAT_1 = 2'h1;
  localparam logic [1:0] LAT_2 = 2'h2;
  localparam logic [1:0] LAT_3 = 2'h3;
  localparam logic [1:0] RST_LAT   = 2'h2;
  localparam logic [7:0] RST_BLEN  = 8'h00;
  localparam logic [7:0] BEAT_ONE  = 8'h01;
  localparam logic [15:0] RST_COLOR = 16'h0000;

  typedef enum logic [1:0] {SGC_IDLE, SGC_RD, SGC_WR} sgc_burst_e;

endpackage

// file: sgc_mem.sv
/*
  Storage array of the core: one wide word per column group of eight,
  split into byte lanes so that any mix of columns and bytes is written in
  a single cycle. Read data come from a register one edge after the address.
  Assumes one write and one read port, both on clk_sys.
*/
`timescale 1ns/1ps
module sgc_mem (
  input  wire logic                         clk_sys,
  input  wire logic                         clkEnable,
  input  wire logic [sgc_pkg::MEM_AW-1:0]   wrAddr,
  input  wire logic [sgc_pkg::WIDE_BE-1:0]  wrByteEn,
  input  wire logic [sgc_pkg::WIDE_W-1:0]   wrData,
  input  wire logic [sgc_pkg::MEM_AW-1:0]   rdAddr,
  output wire logic [sgc_pkg::WIDE_W-1:0]   rdData
);

  // ----------------------------------------------------------------------
  // Byte lanes
  // ----------------------------------------------------------------------
  // Each lane is its own array, so masked bytes are simply not written.
  for (genvar g = 0; g < sgc_pkg::WIDE_BE; g++) begin : gLane
    logic [7:0] store [0:sgc_pkg::MEM_DEPTH-1];
    logic [7:0] laneQ;
    always_ff @(posedge clk_sys) begin
      if (clkEnable) begin
        if (wrByteEn[g]) begin
          store[wrAddr] <= wrData[g*8 +: 8];
        end
        laneQ <= store[rdAddr];
      end
    end
    assign rdData[g*8 +: 8] = laneQ;
  end

endmodule

// file: sgc_core.sv
/*
  Command engine of a two-bank synchronous graphics DRAM: bank tracking,
  burst read and burst write with interruption, block write, precharge
  truncation, read latency pipeline and byte mask handling.
  Assumes a controller on the same clock that keeps all spacing it owes.
*/
`timescale 1ns/1ps

module sgc_core (
  input  wire logic                          clk_sys,
  input  wire logic                          reset_n,
  input  wire logic                          clkEnable,
  input  wire logic                          chipSelect_n,
  input  wire logic                          rowStrobe_n,
  input  wire logic                          colStrobe_n,
  input  wire logic                          writeEnable_n,
  input  wire logic                          blockWrite,
  input  wire logic [sgc_pkg::ADDR_W-1:0]    addr,
  input  wire logic [sgc_pkg::LANES-1:0]     dqMask,
  input  wire logic [sgc_pkg::DATA_W-1:0]    dqIn,
  output logic      [sgc_pkg::DATA_W-1:0]    dqOut,
  output logic      [sgc_pkg::LANES-1:0]     dqOe
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [1:0]                    bankActive;
  logic [sgc_pkg::ROW_W-1:0]     openRow [0:1];
  sgc_pkg::sgc_burst_e           burstMode;
  logic                          burstBank;
  logic [sgc_pkg::COL_W-1:0]     burstStart;
  logic [sgc_pkg::COL_W-1:0]     burstCnt;
  logic [sgc_pkg::COL_W-1:0]     lenMask;
  logic                          interleave;
  logic                          singleWrite;
  logic [1:0]                    readLatency;
  logic [sgc_pkg::DATA_W-1:0]    colorReg;
  logic                          rdValid1;
  logic [sgc_pkg::GRP_SEL_W-1:0] rdSel1;
  logic                          pipeValid1;
  logic                          pipeValid2;
  logic [sgc_pkg::DATA_W-1:0]    pipeData1;
  logic [sgc_pkg::DATA_W-1:0]    pipeData2;
  logic [sgc_pkg::LANES-1:0]     maskD1;
  logic [sgc_pkg::LANES-1:0]     maskD2;

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  // Reads and writes to an idle bank are dropped; the controller must activate first.
  wire logic [3:0] opcode = {chipSelect_n, rowStrobe_n, colStrobe_n, writeEnable_n};
  wire logic       cmdBank = addr[sgc_pkg::BANK_BIT];
  wire logic [sgc_pkg::COL_W-1:0] cmdCol = addr[sgc_pkg::COL_W-1:0];
  wire logic       cmdBankOn = bankActive[cmdBank];
  wire logic       isAct   = (opcode == sgc_pkg::CMD_ACT);
  wire logic       isPre   = (opcode == sgc_pkg::CMD_PRE);
  wire logic       isRead  = (opcode == sgc_pkg::CMD_READ) && cmdBankOn;
  wire logic       isWrite = (opcode == sgc_pkg::CMD_WRITE) && cmdBankOn && !blockWrite;
  wire logic       isBlock = (opcode == sgc_pkg::CMD_WRITE) && cmdBankOn && blockWrite;
  wire logic       isMode  = (opcode == sgc_pkg::CMD_MODE) && !blockWrite;
  wire logic       isSpec  = (opcode == sgc_pkg::CMD_MODE) && blockWrite;
  wire logic       isStop  = (opcode == sgc_pkg::CMD_STOP);
  wire logic       preAll  = addr[sgc_pkg::PRE_ALL_BIT];

  // A precharge of the bursting bank ends the burst; reads then drain and
  // the outputs float exactly one read latency after the precharge.
  wire logic preHitsBurst = isPre && (preAll || (cmdBank == burstBank));
  wire logic stopBurst    = isStop || preHitsBurst;
  wire logic newColumn    = isRead || isWrite || isBlock;
  wire logic contBeat     = (burstMode != sgc_pkg::SGC_IDLE) && !newColumn && !stopBurst;
  wire logic fullPage     = (lenMask == sgc_pkg::MASK_FULL);
  wire logic lastBeat     = (burstCnt == lenMask) && !fullPage;

  // ----------------------------------------------------------------------
  // Burst column generation
  // ----------------------------------------------------------------------
  // The column wraps inside the burst-length block, sequential or interleaved.
  wire logic [sgc_pkg::COL_W-1:0] seqSum  = 8'(burstStart + burstCnt);
  wire logic [sgc_pkg::COL_W-1:0] lowPart = interleave ? (burstStart ^ burstCnt) : seqSum;
  wire logic [sgc_pkg::COL_W-1:0] beatCol = (burstStart & ~lenMask) | (lowPart & lenMask);

  // A fresh command always wins over the burst in flight.
  wire logic wrGo  = isWrite || (contBeat && burstMode == sgc_pkg::SGC_WR);
  wire logic rdGo  = isRead || (contBeat && burstMode == sgc_pkg::SGC_RD);
  wire logic accBank = newColumn ? cmdBank : burstBank;
  wire logic [sgc_pkg::COL_W-1:0] accCol = newColumn ? cmdCol : beatCol;
  wire logic [sgc_pkg::MEM_AW-1:0] accAddr =
    {accBank, openRow[accBank], accCol[sgc_pkg::COL_W-1:sgc_pkg::GRP_SEL_W]};

  // ----------------------------------------------------------------------
  // Write data and byte enables
  // ----------------------------------------------------------------------
  // The byte mask gates write data in the very cycle it is presented.
  logic [sgc_pkg::WIDE_BE-1:0] wrByteEn;
  logic [sgc_pkg::WIDE_W-1:0]  wrData;
  wire logic [sgc_pkg::LANES-1:0] laneOn = ~dqMask;
  for (genvar w = 0; w < sgc_pkg::GRP_WORDS; w++) begin : gWord
    wire logic normalHit = wrGo && (accCol[sgc_pkg::GRP_SEL_W-1:0] == w);
    wire logic blockHit  = isBlock && dqIn[w];
    assign wrByteEn[w*sgc_pkg::LANES +: sgc_pkg::LANES] =
      (normalHit || blockHit) ? laneOn : '0;
    assign wrData[w*sgc_pkg::DATA_W +: sgc_pkg::DATA_W] = isBlock ? colorReg : dqIn;
  end

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [sgc_pkg::WIDE_W-1:0] rdWide;
  sgc_mem uMem (
    .clk_sys   (clk_sys),
    .clkEnable (clkEnable),
    .wrAddr    (accAddr),
    .wrByteEn  (wrByteEn),
    .wrData    (wrData),
    .rdAddr    (accAddr),
    .rdData    (rdWide)
  );
  wire logic [sgc_pkg::DATA_W-1:0] rdWord = rdWide[rdSel1*sgc_pkg::DATA_W +: sgc_pkg::DATA_W];

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  wire logic [2:0] blCode  = addr[sgc_pkg::BL_LSB +: sgc_pkg::BL_W];
  wire logic [2:0] latCode = addr[sgc_pkg::LAT_LSB +: sgc_pkg::LAT_W];
  wire logic latOk = (latCode == 3'(sgc_pkg::LAT_1)) || (latCode == 3'(sgc_pkg::LAT_2))
                     || (latCode == 3'(sgc_pkg::LAT_3));
  logic [sgc_pkg::COL_W-1:0] next_lenMask;
  always_comb begin
    case (blCode)
      sgc_pkg::BL_1:    next_lenMask = sgc_pkg::MASK_1;
      sgc_pkg::BL_2:    next_lenMask = sgc_pkg::MASK_2;
      sgc_pkg::BL_4:    next_lenMask = sgc_pkg::MASK_4;
      sgc_pkg::BL_8:    next_lenMask = sgc_pkg::MASK_8;
      sgc_pkg::BL_FULL: next_lenMask = sgc_pkg::MASK_FULL;
      default:          next_lenMask = lenMask;
    endcase
  end

  // Mode register; unsupported latency codes leave the old latency in place.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      lenMask     <= sgc_pkg::RST_BLEN;
      interleave  <= 1'b0;
      singleWrite <= 1'b0;
      readLatency <= sgc_pkg::RST_LAT;
      colorReg    <= sgc_pkg::RST_COLOR;
    end else if (clkEnable) begin
      if (isMode) begin
        lenMask     <= next_lenMask;
        interleave  <= addr[sgc_pkg::BTYPE_BIT];
        singleWrite <= addr[sgc_pkg::SINGLE_BIT];
        if (latOk) begin
          readLatency <= latCode[1:0];
        end
      end
      // Both load bits set leaves the color untouched.
      if (isSpec && addr[sgc_pkg::COLOR_BIT] && !addr[sgc_pkg::WMASK_BIT]) begin
        colorReg <= dqIn;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Bank tracking
  // ----------------------------------------------------------------------
  // Activating an already open bank is the controller's fault and simply
  // reloads the row; precharge is accepted the cycle after a read.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      bankActive <= 2'h0;
      openRow[0] <= '0;
      openRow[1] <= '0;
    end else if (clkEnable) begin
      if (isAct) begin
        bankActive[cmdBank] <= 1'b1;
        openRow[cmdBank]    <= addr[sgc_pkg::ROW_W-1:0];
      end else if (isPre && preAll) begin
        bankActive <= 2'h0;
      end else if (isPre) begin
        bankActive[cmdBank] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Burst sequencer
  // ----------------------------------------------------------------------
  // Single-word write mode and length one start no burst at all.
  wire logic noBurst = (lenMask == sgc_pkg::MASK_1) || (isWrite && singleWrite);
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      burstMode  <= sgc_pkg::SGC_IDLE;
      burstBank  <= 1'b0;
      burstStart <= '0;
      burstCnt   <= '0;
    end else if (clkEnable) begin
      if (isRead || isWrite) begin
        burstMode  <= noBurst ? sgc_pkg::SGC_IDLE
                    : (isRead ? sgc_pkg::SGC_RD : sgc_pkg::SGC_WR);
        burstBank  <= cmdBank;
        burstStart <= cmdCol;
        burstCnt   <= sgc_pkg::BEAT_ONE;
      end else if (isBlock || stopBurst) begin
        burstMode <= sgc_pkg::SGC_IDLE;
      end else if (contBeat) begin
        if (lastBeat) begin
          burstMode <= sgc_pkg::SGC_IDLE;
        end
        burstCnt <= 8'(burstCnt + sgc_pkg::BEAT_ONE);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read latency pipeline
  // ----------------------------------------------------------------------
  // Storage adds one edge; two more stages cover latencies two and three.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rdValid1   <= 1'b0;
      rdSel1     <= '0;
      pipeValid1 <= 1'b0;
      pipeValid2 <= 1'b0;
      pipeData1  <= '0;
      pipeData2  <= '0;
    end else if (clkEnable) begin
      rdValid1   <= rdGo;
      rdSel1     <= accCol[sgc_pkg::GRP_SEL_W-1:0];
      pipeValid1 <= rdValid1;
      pipeData1  <= rdWord;
      pipeValid2 <= pipeValid1;
      pipeData2  <= pipeData1;
    end
  end

  // Pick the stage that matches the read latency; the float after a
  // precharge follows the same stage, so it lands one latency later.
  logic                        selValid;
  logic [sgc_pkg::DATA_W-1:0]  selData;
  always_comb begin
    case (readLatency)
      sgc_pkg::LAT_1: begin
        selValid = rdValid1;
        selData  = rdWord;
      end
      sgc_pkg::LAT_3: begin
        selValid = pipeValid2;
        selData  = pipeData2;
      end
      default: begin
        selValid = pipeValid1;
        selData  = pipeData1;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Output drivers
  // ----------------------------------------------------------------------
  // The read-side mask acts two edges late, which lets the controller float
  // the outputs ahead of its own write data.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      maskD1 <= '0;
      maskD2 <= '0;
      dqOut  <= '0;
      dqOe   <= '0;
    end else if (clkEnable) begin
      maskD1 <= dqMask;
      maskD2 <= maskD1;
      dqOut  <= selData;
      dqOe   <= {sgc_pkg::LANES{selValid}} & ~maskD2;
    end
  end

endmodule

// file: sgc_core_props.sv
/*
  Checker for the graphics DRAM core: output enables after read, precharge and reset.
  Assumes binding to sgc_core, clkEnable high and no full-page bursts.
*/
`timescale 1ns/1ps
module sgc_core_props (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        clkEnable,
  input wire logic        chipSelect_n,
  input wire logic        rowStrobe_n,
  input wire logic        colStrobe_n,
  input wire logic        writeEnable_n,
  input wire logic        blockWrite,
  input wire logic [9:0]  addr,
  input wire logic [1:0]  dqMask,
  input wire logic [15:0] dqIn,
  input wire logic [15:0] dqOut,
  input wire logic [1:0]  dqOe
);
  // ---------------------------------------------------------------
  // Command decode and a mirror of the read latency
  // ---------------------------------------------------------------
  wire logic [3:0] cmd   = {chipSelect_n, rowStrobe_n, colStrobe_n, writeEnable_n};
  wire logic       isRd  = cmd == sgc_pkg::CMD_READ;
  wire logic       isWr  = cmd == sgc_pkg::CMD_WRITE;
  wire logic       isPre = cmd == sgc_pkg::CMD_PRE && addr[sgc_pkg::PRE_ALL_BIT];
  wire logic       isMod = cmd == sgc_pkg::CMD_MODE && !blockWrite;
  wire logic [2:0] latIn = addr[sgc_pkg::LAT_LSB +: sgc_pkg::LAT_W];
  logic [1:0] lat;
  logic [7:0] sinceRd;
  // Unknown latency codes are ignored, as the core does, so the mirror cannot drift.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      lat <= sgc_pkg::RST_LAT;
      sinceRd <= 8'hff;
    end else begin
      if (isMod && latIn inside {3'h1, 3'h2, 3'h3}) lat <= latIn[1:0];
      if (isRd) sinceRd <= 8'h00;
      else if (sinceRd != 8'hff) sinceRd <= sinceRd + 8'h01;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  rst_quiet_a: assert property ($rose(reset_n) |-> dqOe == 2'h0 && dqOut == 16'h0)
    else $error("outputs not quiet after reset");
  rd_lat_one_a: assert property (dqMask == 2'h0 ##1 (isRd && lat == 2'h1) ##1 !isWr
    |-> ##1 dqOe == 2'h3) else $error("read data missing at latency one");
  rd_lat_two_a: assert property ((isRd && lat == 2'h2 && dqMask == 2'h0) ##1 !isWr
    |-> ##2 dqOe == 2'h3) else $error("read data missing at latency two");
  rd_lat_three_a: assert property (isRd && lat == 2'h3 ##1 (!isWr && dqMask == 2'h0)
    ##1 !isWr |-> ##2 dqOe == 2'h3) else $error("read data missing at latency three");
  pre_float_one_a: assert property (isPre && lat == 2'h1 |-> ##2 dqOe == 2'h0)
    else $error("outputs not floated one cycle after precharge");
  pre_float_two_a: assert property (isPre && lat == 2'h2 |-> ##3 dqOe == 2'h0)
    else $error("outputs not floated two cycles after precharge");
  pre_float_three_a: assert property (isPre && lat == 2'h3 |-> ##4 dqOe == 2'h0)
    else $error("outputs not floated three cycles after precharge");
  idle_float_a: assert property (sinceRd > 8'd14 |-> dqOe == 2'h0)
    else $error("outputs driven long after the last read");
endmodule
bind sgc_core sgc_core_props chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .clkEnable(clkEnable), .chipSelect_n(chipSelect_n), .rowStrobe_n(rowStrobe_n),
  .colStrobe_n(colStrobe_n), .writeEnable_n(writeEnable_n), .blockWrite(blockWrite),
  .addr(addr), .dqMask(dqMask), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe));

// file: sgc_ctl_model.sv
/*
  Behavioural memory controller that issues commands to the core.
  Assumes its tasks are called just after a rising edge of clk_sys.
*/
`timescale 1ns/1ps
module sgc_ctl_model #(
  parameter int BWC_CYC = 2
) (
  input  wire logic        clk_sys,
  output logic             clkEnable,
  output logic             chipSelect_n,
  output logic             rowStrobe_n,
  output logic             colStrobe_n,
  output logic             writeEnable_n,
  output logic             blockWrite,
  output logic [9:0]       addr,
  output logic [1:0]       dqMask,
  output logic [15:0]      dqIn
);
  logic       bankOn  [2];
  logic [8:0] bankRow [2];
  // Power-up: clock enabled, device deselected and byte mask high.
  initial begin
    {clkEnable, chipSelect_n, rowStrobe_n, colStrobe_n, writeEnable_n} = 5'h1f;
    blockWrite = 1'b0;
    addr = 10'h000;
    dqMask = 2'h3;
    dqIn = 16'h0000;
    bankOn = '{1'b0, 1'b0};
  end
  // One command, taken at the next edge; the task returns just after it.
  task automatic issue(input logic [3:0] c, input logic bw, input logic [9:0] a,
                       input logic [1:0] m, input logic [15:0] d);
    {chipSelect_n, rowStrobe_n, colStrobe_n, writeEnable_n} = c;
    blockWrite = bw;
    addr = a;
    dqMask = m;
    dqIn = d;
    @(posedge clk_sys);
    #1;
  endtask
  // Idle lines are inverted so that stale values never look valid.
  task automatic beat(input logic [15:0] d, input logic [1:0] m);
    issue(4'hf, 1'b0, ~addr, m, d);
  endtask
  task automatic nop(input int n);
    repeat (n) beat(~dqIn, 2'h0);
  endtask
  task automatic preAll();
    issue(sgc_pkg::CMD_PRE, 1'b0, 10'h100, 2'h3, ~dqIn);
    bankOn = '{1'b0, 1'b0};
  endtask
  task automatic mode(input logic [2:0] lat, input logic [2:0] bl);
    preAll();
    issue(sgc_pkg::CMD_MODE, 1'b0, {3'h0, lat, 1'b0, bl}, 2'h3, ~dqIn);
  endtask
  // Bank state is tracked so another row is reached only by precharge and activate.
  task automatic openRow(input logic b, input logic [8:0] row);
    if (bankOn[b] && bankRow[b] != row) begin
      issue(sgc_pkg::CMD_PRE, 1'b0, {b, 9'h000}, 2'h0, ~dqIn);
      bankOn[b] = 1'b0;
    end
    if (!bankOn[b]) begin
      issue(sgc_pkg::CMD_ACT, 1'b0, {b, row}, 2'h0, ~dqIn);
      bankOn[b] = 1'b1;
      bankRow[b] = row;
    end
  endtask
  // The core does not guard the block-write cycle time, so no-ops cover it here.
  task automatic blk(input logic b, input logic [7:0] c, input logic [7:0] sel);
    issue(sgc_pkg::CMD_WRITE, 1'b1, {b, 1'b0, c}, 2'h0, {8'h00, sel});
    nop(BWC_CYC - 1);
  endtask
endmodule

// file: tb_sgc_core.sv
/*
  Self-checking testbench of the graphics DRAM core.
  Assumes the controller model drives every command input of the core.
*/
`timescale 1ns/1ps
module tb_sgc_core;
  logic        clk_sys;
  logic        reset_n;
  logic        clkEnable;
  logic        chipSelect_n;
  logic        rowStrobe_n;
  logic        colStrobe_n;
  logic        writeEnable_n;
  logic        blockWrite;
  logic [9:0]  addr;
  logic [1:0]  dqMask;
  logic [15:0] dqIn;
  logic [15:0] dqOut;
  logic [1:0]  dqOe;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;
  sgc_core dut (.clk_sys(clk_sys), .reset_n(reset_n), .clkEnable(clkEnable),
    .chipSelect_n(chipSelect_n), .rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n),
    .writeEnable_n(writeEnable_n), .blockWrite(blockWrite), .addr(addr),
    .dqMask(dqMask), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe));
  // Five cycles of 5 ns cover a 25 ns block-write cycle time.
  sgc_ctl_model #(.BWC_CYC(5)) ctl (.clk_sys(clk_sys), .clkEnable(clkEnable),
    .chipSelect_n(chipSelect_n), .rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n),
    .writeEnable_n(writeEnable_n), .blockWrite(blockWrite), .addr(addr),
    .dqMask(dqMask), .dqIn(dqIn));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic b, input logic [7:0] c, input logic [15:0] d);
    ctl.issue(sgc_pkg::CMD_WRITE, 1'b0, {b, 1'b0, c}, 2'h0, d);
  endtask
  task automatic wr4(input logic b, input logic [7:0] c, input logic [15:0] e [4]);
    wr(b, c, e[0]);
    for (int i = 1; i < 4; i++) ctl.beat(e[i], 2'h0);
  endtask
  // Words of a read appear one per cycle, the read latency after the command edge.
  task automatic rd(input logic b, input logic [7:0] c, input int lat, input int n,
                    input logic [15:0] e [4]);
    ctl.issue(sgc_pkg::CMD_READ, 1'b0, {b, 1'b0, c}, 2'h0, ~dqIn);
    ctl.nop(lat);
    for (int i = 0; i < n; i++) begin
      if (i > 0) ctl.nop(1);
      check(dqOut, e[i]);
      check({14'h0, dqOe}, 16'h0003);
    end
  endtask
  task automatic rd1(input logic b, input logic [7:0] c, input logic [15:0] w);
    rd(b, c, 2, 1, '{w, w, w, w});
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_lat();
    logic [15:0] e [4];
    for (int l = 1; l <= 3; l++) begin
      ctl.mode(3'(l), sgc_pkg::BL_4);
      ctl.openRow(1'b0, 9'h005);
      for (int i = 0; i < 4; i++) e[i] = 16'(l * 4352 + i);
      wr4(1'b0, 8'h00, e);
      rd(1'b0, 8'h00, l, 4, e);
      ctl.issue(sgc_pkg::CMD_READ, 1'b0, 10'h000, 2'h0, ~dqIn);
      ctl.preAll();
      ctl.nop(l - 1);
      check(dqOut, e[0]);
      ctl.nop(1);
      check({14'h0, dqOe}, 16'h0000);
      // A precharge placed the lead before the last word keeps the whole burst.
      ctl.openRow(1'b0, 9'h005);
      ctl.issue(sgc_pkg::CMD_READ, 1'b0, 10'h000, 2'h0, ~dqIn);
      for (int k = 1; k <= l + 4; k++) begin
        if (k == 4) ctl.preAll();
        else ctl.nop(1);
        if (k >= l && k < l + 4) check(dqOut, e[k - l]);
      end
      check({14'h0, dqOe}, 16'h0000);
    end
  endtask
  task automatic t_cut();
    ctl.mode(3'h2, sgc_pkg::BL_4);
    ctl.openRow(1'b0, 9'h007);
    wr4(1'b0, 8'h00, '{16'hc0c0, 16'hc1c1, 16'hc2c2, 16'hc3c3});
    wr(1'b0, 8'h00, 16'ha0a0);
    ctl.beat(16'ha1a1, 2'h2);
    wr(1'b0, 8'h08, 16'hb0b0);
    ctl.beat(16'hb1b1, 2'h0);
    rd(1'b0, 8'h00, 2, 4, '{16'ha0a0, 16'hc1a1, 16'hc2c2, 16'hc3c3});
    // Read masked ahead so the pins float before write data arrive.
    ctl.issue(sgc_pkg::CMD_READ, 1'b0, 10'h000, 2'h3, ~dqIn);
    wr4(1'b0, 8'h04, '{16'hd0d0, 16'hd1d1, 16'hd2d2, 16'hd3d3});
    check({14'h0, dqOe}, 16'h0000);
    rd(1'b0, 8'h04, 2, 4, '{16'hd0d0, 16'hd1d1, 16'hd2d2, 16'hd3d3});
    // The unfinished beat is masked, so the early precharge stores nothing stale.
    wr(1'b0, 8'h04, 16'he0e0);
    ctl.beat(16'he1e1, 2'h3);
    ctl.preAll();
    ctl.openRow(1'b0, 9'h007);
    rd(1'b0, 8'h04, 2, 4, '{16'he0e0, 16'hd1d1, 16'hd2d2, 16'hd3d3});
  endtask
  task automatic t_bank();
    ctl.mode(3'h2, sgc_pkg::BL_1);
    ctl.openRow(1'b0, 9'h001);
    ctl.openRow(1'b1, 9'h002);
    wr(1'b0, 8'h15, 16'h5a5a);
    wr(1'b1, 8'h15, 16'ha5a5);
    wr(1'b1, 8'h16, 16'h6b6b);
    wr(1'b0, 8'h16, 16'h3c3c);
    rd1(1'b1, 8'h15, 16'ha5a5);
    rd1(1'b0, 8'h15, 16'h5a5a);
    rd1(1'b0, 8'h16, 16'h3c3c);
    rd1(1'b1, 8'h16, 16'h6b6b);
    wr(1'b0, 8'h21, 16'h7777);
    ctl.issue(sgc_pkg::CMD_MODE, 1'b1, 10'h040, 2'h0, 16'h9e9e);
    ctl.blk(1'b0, 8'h20, 8'h05);
    rd1(1'b1, 8'h15, 16'ha5a5);
    rd1(1'b0, 8'h20, 16'h9e9e);
    rd1(1'b0, 8'h21, 16'h7777);
    rd1(1'b0, 8'h22, 16'h9e9e);
    // Another row of bank one: single-bank precharge, activate, and back again.
    ctl.openRow(1'b1, 9'h003);
    wr(1'b1, 8'h15, 16'h4242);
    rd1(1'b1, 8'h15, 16'h4242);
    ctl.openRow(1'b1, 9'h002);
    rd1(1'b1, 8'h15, 16'ha5a5);
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // The run needs well under a thousand cycles; the ceiling only cuts a hang.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    reset_n = 1'b0;
    repeat (16) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    t_lat();
    t_cut();
    t_bank();
    end_of_test();
  end
endmodule
